/* File: olsat_top.sv */
// output level select and limit-cycle autotune, one channel
// assumes an axi4-lite master, synchronous inputs, one clock
// What this block does
// - manual mode outputs stored manual level
// - override levels range-checked, default zero
// - mode input off auto, on manual
// - status word reports auto or manual
// - stopped control outputs stopped level
// - heat/cool stopped level split by sign
// - zero stopped level gives no output
// - input error outputs error level
// - priority manual, stopped, then error
// - clamp computed level; overrides bypass
// - heat/cool uses one combined limit pair
// - heat/cool limit ranges and defaults
// - lower above upper: larger acts upper
// - clamp only two-dof, self-tune off
// - refuse tune stopped, manual, on/off
// - during tuning only run/mode/tune/latch writes
// - stop cancels tune, no resume
// - no reduced tune under heat/cool
// - tune gain 0.1..10.0, default 0.8
// - tune hysteresis toggles limit cycle
// - reduced swing 5.0..50.0, default 20.0
// - reduced waits on deviation; full ignores
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module olsat_top
  import olsat_pkg::*;
#(
  parameter int LW = LVL_W
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 mode_event_en,
  input  wire logic                 mode_event_in,
  input  wire logic                 input_error,
  input  wire logic signed [LW-1:0] computed_level,
  input  wire logic signed [15:0]   initial_deviation,
  input  wire logic signed [15:0]   measured_value,
  input  wire logic signed [15:0]   set_point,
  output logic signed [LW-1:0]      output_level,
  output logic [LW-1:0]             heat_level,
  output logic [LW-1:0]             cool_level,
  output logic                      tune_active,
  output logic                      latch_clear,
  output logic [15:0]               tune_gain
);
  typedef struct packed {
    logic                 awdone;
    logic                 wdone;
    logic [7:0]           awaddr;
    logic [31:0]          wdata;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic                 run;
    logic                 manual;
    logic                 heatcool;
    logic                 onoff;
    logic                 twodof;
    logic                 selftune;
    logic                 reduced;
    logic                 refused;
    logic                 latch;
    logic signed [LW-1:0] lvl_manual;
    logic signed [LW-1:0] lvl_stop;
    logic signed [LW-1:0] lvl_error;
    logic signed [LW-1:0] upper;
    logic signed [LW-1:0] lower;
    logic [15:0]          gain;
    logic [15:0]          hyst;
    logic [15:0]          swing;
    logic [15:0]          judge;
    olsat_tune_type       tune;
    logic                 high;
    logic signed [LW-1:0] out;
  } olsat_state_type;

  olsat_state_type q, d;

  logic                 manual_eff;
  logic                 wr_go;
  logic                 locked;
  logic                 clamp_on;
  logic signed [LW-1:0] eff_up;
  logic signed [LW-1:0] eff_lo;
  logic signed [LW-1:0] clamped;
  logic signed [LW-1:0] wlvl;
  logic signed [LW-1:0] swing_lvl;
  logic signed [LW-1:0] sel;
  logic signed [LW-1:0] lvl_min;
  logic signed [16:0]   err;
  logic                 in_range;

  function automatic logic lvl_ok(input logic signed [LW-1:0] v, input logic signed [LW-1:0] lo,
                                  input logic signed [LW-1:0] hi);
    lvl_ok = (v >= lo) && (v <= hi);
  endfunction

  assign manual_eff = mode_event_en ? mode_event_in : q.manual;
  assign wr_go      = q.awdone && q.wdone && !q.bvalid;
  assign locked     = (q.tune != TUNE_IDLE) && (q.awaddr != REG_CTRL);
  assign wlvl       = q.wdata[LW-1:0];
  assign lvl_min    = q.heatcool ? LVL_HC_MIN : LVL_STD_MIN;
  assign in_range   = lvl_ok(wlvl, lvl_min, LVL_MAX);
  assign clamp_on   = q.twodof && !q.selftune;
  assign eff_up     = (q.lower > q.upper) ? q.lower : q.upper;
  assign eff_lo     = (q.lower > q.upper) ? q.upper : q.lower;
  // one limit pair on the signed sum, heat/cool alike
  assign clamped    = (computed_level > eff_up) ? eff_up :
                      (computed_level < eff_lo) ? eff_lo : computed_level;
  assign swing_lvl  = q.reduced ? LW'(q.swing) : LVL_MAX;
  assign err        = 17'(set_point) - 17'(measured_value);

  always_comb begin
    d = q;
    s_axi_awready = !q.awdone && !q.bvalid;
    s_axi_wready  = !q.wdone && !q.bvalid;
    s_axi_arready = !q.rvalid;
    d.latch = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      d.awdone = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.wdone = 1'b1;
      d.wdata = s_axi_wdata;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (wr_go) begin
      d.awdone = 1'b0;
      d.wdone  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      if (locked) begin
        d.bresp = RESP_SLVERR;
      end else begin
        unique case (q.awaddr)
          REG_CTRL: begin
            d.run    = q.wdata[CTRL_RUN];
            d.manual = q.wdata[CTRL_MANUAL];
            d.latch  = q.wdata[CTRL_LATCH_CL];
            if (q.tune == TUNE_IDLE) begin
              d.heatcool = q.wdata[CTRL_HEATCOOL];
              d.onoff    = q.wdata[CTRL_ONOFF];
              d.twodof   = q.wdata[CTRL_TWODOF];
              d.selftune = q.wdata[CTRL_SELFTUNE];
              d.reduced  = q.wdata[CTRL_REDUCED] && !q.wdata[CTRL_HEATCOOL];
            end
            if (q.wdata[CTRL_TUNE_GO] && q.tune == TUNE_IDLE) begin
              if (!q.run || manual_eff || q.onoff) begin
                d.refused = 1'b1;
              end else begin
                d.refused = 1'b0;
                d.tune    = TUNE_WAIT;
                d.high    = 1'b1;
              end
            end
            if (q.wdata[CTRL_TUNE_CAN]) begin
              d.tune = TUNE_IDLE;
            end
          end
          REG_MANUAL: if (in_range) d.lvl_manual = wlvl; else d.bresp = RESP_SLVERR;
          REG_STOP:   if (in_range) d.lvl_stop = wlvl; else d.bresp = RESP_SLVERR;
          REG_ERROR:  if (in_range) d.lvl_error = wlvl; else d.bresp = RESP_SLVERR;
          REG_UPPER: begin
            if (lvl_ok(wlvl, q.heatcool ? LVL_ZERO : LVL_STD_MIN, LVL_MAX)) d.upper = wlvl;
            else d.bresp = RESP_SLVERR;
          end
          REG_LOWER: begin
            if (lvl_ok(wlvl, lvl_min, q.heatcool ? LVL_ZERO : LVL_MAX)) d.lower = wlvl;
            else d.bresp = RESP_SLVERR;
          end
          REG_GAIN: begin
            if (q.wdata[15:0] >= GAIN_MIN && q.wdata[15:0] <= GAIN_MAX) d.gain = q.wdata[15:0];
            else d.bresp = RESP_SLVERR;
          end
          REG_HYST: begin
            if (q.wdata[15:0] >= HYST_MIN && q.wdata[15:0] <= HYST_MAX) d.hyst = q.wdata[15:0];
            else d.bresp = RESP_SLVERR;
          end
          REG_SWING: begin
            if (q.wdata[15:0] >= SWING_MIN && q.wdata[15:0] <= SWING_MAX) d.swing = q.wdata[15:0];
            else d.bresp = RESP_SLVERR;
          end
          REG_JUDGE: d.judge = q.wdata[15:0];
          default:   d.bresp = RESP_SLVERR;
        endcase
      end
    end
    // limit-cycle sequencing
    unique case (q.tune)
      TUNE_IDLE: ;
      TUNE_WAIT: begin
        // reduced variant holds off until deviation is under the judgment threshold
        if (!q.reduced || initial_deviation < $signed({1'b0, q.judge[14:0]})) begin
          d.tune = TUNE_CYCLE;
        end
      end
      TUNE_CYCLE: begin
        if (q.high && err < -$signed({1'b0, q.hyst})) d.high = 1'b0;
        else if (!q.high && err > $signed({1'b0, q.hyst})) d.high = 1'b1;
      end
      default: d.tune = TUNE_IDLE;
    endcase
    if (!d.run || manual_eff) begin
      d.tune = TUNE_IDLE;
    end
    // output selection
    if (manual_eff) sel = q.lvl_manual;
    else if (!q.run) sel = q.lvl_stop;
    else if (input_error) sel = q.lvl_error;
    else if (q.tune == TUNE_CYCLE) sel = q.high ? swing_lvl : (q.heatcool ? -swing_lvl : LVL_ZERO);
    else if (q.tune == TUNE_WAIT) sel = LVL_ZERO;
    else sel = clamp_on ? clamped : computed_level;
    d.out = sel;
    // read side
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = '0;
      unique case (s_axi_araddr)
        REG_CTRL:   d.rdata = {25'h0, q.reduced, q.selftune, q.twodof, q.onoff, q.heatcool, q.manual, q.run};
        REG_MANUAL: d.rdata = 32'(q.lvl_manual);
        REG_STOP:   d.rdata = 32'(q.lvl_stop);
        REG_ERROR:  d.rdata = 32'(q.lvl_error);
        REG_UPPER:  d.rdata = 32'(q.upper);
        REG_LOWER:  d.rdata = 32'(q.lower);
        REG_GAIN:   d.rdata = {16'h0, q.gain};
        REG_HYST:   d.rdata = {16'h0, q.hyst};
        REG_SWING:  d.rdata = {16'h0, q.swing};
        REG_JUDGE:  d.rdata = {16'h0, q.judge};
        REG_STATUS: d.rdata = {26'h0, q.high, q.tune == TUNE_CYCLE, q.refused, q.tune != TUNE_IDLE,
                               q.run, manual_eff};
        default:    d.rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q            <= '0;
      q.upper      <= UPPER_RST;
      q.lower      <= LOWER_RST;
      q.lvl_manual <= LVL_ZERO;
      q.lvl_stop   <= LVL_ZERO;
      q.lvl_error  <= LVL_ZERO;
      q.gain       <= GAIN_RST;
      q.hyst       <= HYST_RST;
      q.swing      <= SWING_RST;
      q.judge      <= JUDGE_RST;
      q.twodof     <= 1'b1;
      q.tune       <= TUNE_IDLE;
    end else begin
      q <= d;
    end
  end

  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp  = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata  = q.rdata;
  assign s_axi_rresp  = q.rresp;
  assign output_level = q.out;
  // heat takes positive, cool the magnitude of negative in heat/cool only
  assign heat_level   = (q.out > LVL_ZERO) ? q.out : LVL_ZERO;
  assign cool_level   = (q.heatcool && q.out < LVL_ZERO) ? -q.out : LVL_ZERO;
  assign tune_active  = q.tune != TUNE_IDLE;
  assign latch_clear  = q.latch;
  assign tune_gain    = q.gain;

  AST_MANUAL_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
    manual_eff |=> output_level == $past(q.lvl_manual)) else $error("manual level not output");
  AST_STOP_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
    (!manual_eff && !q.run) |=> output_level == $past(q.lvl_stop)) else $error("stop level not output");
  AST_ERR_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
    (!manual_eff && q.run && input_error) |=> output_level == $past(q.lvl_error))
    else $error("error level not output");
  AST_CLAMP: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.run && !manual_eff && !input_error && q.tune == TUNE_IDLE && clamp_on)
    |=> output_level <= $past(eff_up) && output_level >= $past(eff_lo)) else $error("clamp broken");
  AST_SPLIT: assert property (@(posedge aclk) disable iff (!aresetn)
    q.out == LVL_ZERO |-> heat_level == LVL_ZERO && cool_level == LVL_ZERO) else $error("output at zero");
  AST_REFUSE: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.tune == TUNE_IDLE && (!q.run || q.onoff)) |=> q.tune == TUNE_IDLE) else $error("tune not refused");
  AST_STOP_CANCEL: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.tune != TUNE_IDLE && !d.run) |=> q.tune == TUNE_IDLE ##1 q.tune == TUNE_IDLE)
    else $error("stop did not cancel tune");
  AST_LOCKED: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && locked) |=> s_axi_bresp == RESP_SLVERR && $stable(q.lvl_manual)) else $error("write not refused");
  AST_NO_REDUCED_HC: assert property (@(posedge aclk) disable iff (!aresetn)
    q.heatcool |-> !q.reduced) else $error("reduced tune under heat/cool");
  AST_WR_RESP: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_axi_bvalid) else $error("no write response");
endmodule
`default_nettype wire

/* File: olsat_pkg.sv */
// package for the output level select and autotune block
// assumes a single 10 MHz clock domain and an axi4-lite register bus
package olsat_pkg;
  // output levels in tenths of a percent, signed
  localparam int LVL_W = 12;
  localparam logic signed [LVL_W-1:0] LVL_STD_MIN  = -12'sd50;
  localparam logic signed [LVL_W-1:0] LVL_HC_MIN   = -12'sd1050;
  localparam logic signed [LVL_W-1:0] LVL_MAX      = 12'sd1050;
  localparam logic signed [LVL_W-1:0] LVL_ZERO     = 12'sd0;
  localparam logic signed [LVL_W-1:0] UPPER_RST    = 12'sd1050;
  localparam logic signed [LVL_W-1:0] LOWER_RST    = -12'sd1050;
  // tuning settings, tenths
  localparam logic [15:0] GAIN_MIN  = 16'h0001;
  localparam logic [15:0] GAIN_MAX  = 16'h0064;
  localparam logic [15:0] GAIN_RST  = 16'h0008;
  localparam logic [15:0] HYST_MIN  = 16'h0001;
  localparam logic [15:0] HYST_MAX  = 16'h270F;
  localparam logic [15:0] HYST_RST  = 16'h0008;
  localparam logic [15:0] SWING_MIN = 16'h0032;
  localparam logic [15:0] SWING_MAX = 16'h01F4;
  localparam logic [15:0] SWING_RST = 16'h00C8;
  localparam logic [15:0] JUDGE_RST = 16'h05DC;
  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_MANUAL = 8'h04;
  localparam logic [7:0] REG_STOP   = 8'h08;
  localparam logic [7:0] REG_ERROR  = 8'h0C;
  localparam logic [7:0] REG_UPPER  = 8'h10;
  localparam logic [7:0] REG_LOWER  = 8'h14;
  localparam logic [7:0] REG_GAIN   = 8'h18;
  localparam logic [7:0] REG_HYST   = 8'h1C;
  localparam logic [7:0] REG_SWING  = 8'h20;
  localparam logic [7:0] REG_JUDGE  = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  // control register fields
  localparam int CTRL_RUN      = 0;
  localparam int CTRL_MANUAL   = 1;
  localparam int CTRL_HEATCOOL = 2;
  localparam int CTRL_ONOFF    = 3;
  localparam int CTRL_TWODOF   = 4;
  localparam int CTRL_SELFTUNE = 5;
  localparam int CTRL_REDUCED  = 6;
  localparam int CTRL_TUNE_GO  = 8;
  localparam int CTRL_TUNE_CAN = 9;
  localparam int CTRL_LATCH_CL = 10;
  // status fields
  localparam int STAT_MANUAL  = 0;
  localparam int STAT_RUN     = 1;
  localparam int STAT_TUNING  = 2;
  localparam int STAT_REFUSED = 3;
  localparam int STAT_PHASE   = 4;
  localparam int STAT_HIGH    = 5;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {TUNE_IDLE = 2'b00, TUNE_WAIT = 2'b01, TUNE_CYCLE = 2'b11} olsat_tune_type;
endpackage

/* File: olsat_actuator.sv */
// heater and cooler actuator model driven by the split output levels
// assumes magnitudes in tenths of a percent, one clock domain
`timescale 1ns/100ps
`default_nettype none
module olsat_actuator (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [11:0]   heat_level,
  input  wire logic [11:0]   cool_level,
  output logic signed [12:0] net_drive,
  output logic               both_on
);
  // heater pushes up, cooler pulls down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      net_drive <= '0;
      both_on   <= 1'b0;
    end else begin
      net_drive <= $signed({1'b0, heat_level}) - $signed({1'b0, cool_level});
      both_on   <= (heat_level != '0) && (cool_level != '0);
    end
  end
endmodule
`default_nettype wire

/* File: olsat_top_tb.sv */
// self-checking bench for the output level select and autotune block
// assumes the package constants and an axi4-lite slave on the register port
`timescale 1ns/100ps
`default_nettype none
module olsat_top_tb;
  import olsat_pkg::*;
  logic              aclk, aresetn = 1'b0;
  logic [7:0]        awaddr = '0, araddr = '0;
  logic [31:0]       wdata = '0, rdata, rd;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, tune_active, latch_clear, both_on;
  logic [1:0]        bresp, rresp, rsp;
  logic              mode_en = 1'b0, mode_in = 1'b0, in_err = 1'b0, latch_seen = 1'b0;
  logic signed [11:0] comp = '0, out_lvl;
  logic [11:0]       heat, cool;
  logic signed [15:0] dev = '0, meas = '0, setp = '0;
  logic [15:0]       gain;
  logic signed [12:0] drive;
  int                n_fail = 0, num_checks = 0, cyc = 0;

  olsat_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mode_event_en(mode_en),
    .mode_event_in(mode_in), .input_error(in_err), .computed_level(comp), .initial_deviation(dev),
    .measured_value(meas), .set_point(setp), .output_level(out_lvl), .heat_level(heat), .cool_level(cool),
    .tune_active(tune_active), .latch_clear(latch_clear), .tune_gain(gain));
  olsat_actuator load (.aclk(aclk), .aresetn(aresetn), .heat_level(heat), .cool_level(cool),
    .net_drive(drive), .both_on(both_on));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (latch_clear === 1'b1) latch_seen = 1'b1;
    if (cyc == 5000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic final_report;
    if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_lvl(input string nm, input logic signed [12:0] e, input logic signed [12:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  function automatic logic [31:0] sx(input logic signed [11:0] v);
    return {{20{v[11]}}, v};
  endfunction
  task automatic settle;
    repeat (4) @(negedge aclk);
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ra, rw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ra = awready & awvalid;
      rw = wready & wvalid;
      @(posedge aclk);
      if (ra === 1'b1) awvalid <= 1'b0;
      if (rw === 1'b1) wvalid <= 1'b0;
      da = da | (ra === 1'b1);
      dw = dw | (rw === 1'b1);
    end while (!(da && dw));
    do begin
      @(negedge aclk);
      ra = bvalid;
      rsp = bresp;
      @(posedge aclk);
    end while (ra !== 1'b1);
    bready <= 1'b0;
    chk_word("write response", 32'(er), 32'(rsp));
    settle();
  endtask
  task automatic rdx(input logic [7:0] a);
    logic ra;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ra = arready;
      @(posedge aclk);
    end while (ra !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      ra = rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge aclk);
    end while (ra !== 1'b1);
    rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    rdx(a);
    chk_word($sformatf("register %h", a), e, rd);
    chk_word("read response", 32'(er), 32'(rsp));
  endtask

  task automatic s_defaults;
    rdc(REG_MANUAL, 32'h0, RESP_OKAY);
    rdc(REG_STOP, 32'h0, RESP_OKAY);
    rdc(REG_ERROR, 32'h0, RESP_OKAY);
    rdc(REG_UPPER, sx(UPPER_RST), RESP_OKAY);
    rdc(REG_LOWER, sx(LOWER_RST), RESP_OKAY);
    rdc(REG_GAIN, 32'(GAIN_RST), RESP_OKAY);
    rdc(REG_SWING, 32'(SWING_RST), RESP_OKAY);
    rdc(8'h30, 32'h0, RESP_SLVERR);
    chk_word("tune_gain", 32'(GAIN_RST), 32'(gain));
  endtask
  task automatic s_ranges;
    wrc(REG_MANUAL, sx(1051), RESP_SLVERR);
    wrc(REG_MANUAL, sx(-51), RESP_SLVERR);
    rdc(REG_MANUAL, 32'h0, RESP_OKAY);
    wrc(REG_MANUAL, sx(LVL_STD_MIN), RESP_OKAY);
    rdc(REG_MANUAL, sx(LVL_STD_MIN), RESP_OKAY);
    wrc(REG_STATUS, 32'h0, RESP_SLVERR);
    wrc(REG_GAIN, 32'h0, RESP_SLVERR);
    wrc(REG_GAIN, 32'(GAIN_MAX), RESP_OKAY);
    chk_word("tune_gain", 32'(GAIN_MAX), 32'(gain));
  endtask
  task automatic s_clamp;
    wrc(REG_CTRL, 32'h11, RESP_OKAY);
    wrc(REG_UPPER, sx(800), RESP_OKAY);
    @(posedge aclk);
    comp <= 12'sd900;
    settle();
    chk_lvl("clamped high", 800, out_lvl);
    @(posedge aclk);
    comp <= -12'sd1100;
    settle();
    chk_lvl("clamped low", -1050, out_lvl);
    wrc(REG_UPPER, sx(300), RESP_OKAY);
    wrc(REG_LOWER, sx(500), RESP_OKAY);
    @(posedge aclk);
    comp <= 12'sd900;
    settle();
    chk_lvl("swapped limits", 500, out_lvl);
    wrc(REG_CTRL, 32'h31, RESP_OKAY);
    chk_lvl("self tune on", 900, out_lvl);
    wrc(REG_CTRL, 32'h01, RESP_OKAY);
    chk_lvl("two dof off", 900, out_lvl);
    wrc(REG_LOWER, sx(-50), RESP_OKAY);
  endtask
  task automatic s_override;
    wrc(REG_UPPER, sx(100), RESP_OKAY);
    wrc(REG_MANUAL, sx(300), RESP_OKAY);
    wrc(REG_STOP, sx(200), RESP_OKAY);
    wrc(REG_ERROR, sx(150), RESP_OKAY);
    wrc(REG_CTRL, 32'h11, RESP_OKAY);
    @(posedge aclk);
    in_err <= 1'b1;
    settle();
    chk_lvl("error level", 150, out_lvl);
    wrc(REG_CTRL, 32'h10, RESP_OKAY);
    chk_lvl("stop over error", 200, out_lvl);
    wrc(REG_CTRL, 32'h12, RESP_OKAY);
    chk_lvl("manual over all", 300, out_lvl);
    rdx(REG_STATUS);
    chk_word("status manual", 32'h1, 32'(rd[STAT_MANUAL]));
    wrc(REG_CTRL, 32'h13, RESP_OKAY);
    @(posedge aclk);
    mode_en <= 1'b1;
    settle();
    chk_lvl("event off auto", 150, out_lvl);
    rdx(REG_STATUS);
    chk_word("status auto", 32'h0, 32'(rd[STAT_MANUAL]));
    @(posedge aclk);
    mode_in <= 1'b1;
    settle();
    chk_lvl("event on manual", 300, out_lvl);
    rdx(REG_STATUS);
    chk_word("status manual", 32'h1, 32'(rd[STAT_MANUAL]));
    @(posedge aclk);
    mode_en <= 1'b0;
    mode_in <= 1'b0;
    in_err <= 1'b0;
  endtask
  task automatic s_heatcool;
    wrc(REG_CTRL, 32'h14, RESP_OKAY);
    wrc(REG_UPPER, sx(-10), RESP_SLVERR);
    wrc(REG_STOP, sx(-400), RESP_OKAY);
    chk_lvl("cool side", 400, $signed({1'b0, cool}));
    chk_lvl("actuator drive", -400, drive);
    wrc(REG_STOP, sx(400), RESP_OKAY);
    chk_lvl("heat side", 400, $signed({1'b0, heat}));
    wrc(REG_STOP, 32'h0, RESP_OKAY);
    chk_lvl("idle drive", 0, drive);
    chk_word("both sides", 32'h0, 32'({heat, cool}));
    wrc(REG_CTRL, 32'h15, RESP_OKAY);
    @(posedge aclk);
    comp <= -12'sd1100;
    settle();
    chk_lvl("combined low limit", 50, $signed({1'b0, cool}));
    wrc(REG_CTRL, 32'h54, RESP_OKAY);
    rdx(REG_CTRL);
    chk_word("reduced bit", 32'h0, 32'(rd[CTRL_REDUCED]));
  endtask
  task automatic s_tune;
    wrc(REG_CTRL, 32'h110, RESP_OKAY);
    rdx(REG_STATUS);
    chk_word("refused stopped", 32'h8, 32'({rd[STAT_REFUSED], rd[STAT_TUNING:0]}));
    wrc(REG_CTRL, 32'h19, RESP_OKAY);
    wrc(REG_CTRL, 32'h119, RESP_OKAY);
    chk_word("refused on/off", 32'h0, 32'(tune_active));
    wrc(REG_CTRL, 32'h13, RESP_OKAY);
    wrc(REG_CTRL, 32'h113, RESP_OKAY);
    chk_word("refused manual", 32'h0, 32'(tune_active));
    wrc(REG_CTRL, 32'h51, RESP_OKAY);
    @(posedge aclk);
    dev <= 16'sd2000;
    setp <= 16'sd100;
    wrc(REG_CTRL, 32'h151, RESP_OKAY);
    chk_word("tune on", 32'h1, 32'(tune_active));
    chk_lvl("waiting", 0, out_lvl);
    @(posedge aclk);
    dev <= 16'sd100;
    settle();
    chk_lvl("swing high", 200, out_lvl);
    wrc(REG_MANUAL, sx(5), RESP_SLVERR);
    wrc(REG_CTRL, 32'h451, RESP_OKAY);
    chk_word("latch clear", 32'h1, 32'(latch_seen));
    @(posedge aclk);
    setp <= 16'sd0;
    meas <= 16'sd100;
    settle();
    chk_lvl("swing low", 0, out_lvl);
    wrc(REG_CTRL, 32'h50, RESP_OKAY);
    wrc(REG_CTRL, 32'h51, RESP_OKAY);
    chk_word("no resume", 32'h0, 32'(tune_active));
    wrc(REG_CTRL, 32'h11, RESP_OKAY);
    @(posedge aclk);
    dev <= 16'sd2000;
    setp <= 16'sd100;
    meas <= 16'sd0;
    wrc(REG_CTRL, 32'h111, RESP_OKAY);
    chk_lvl("full swing", 1050, out_lvl);
    wrc(REG_CTRL, 32'h211, RESP_OKAY);
    chk_word("cancelled", 32'h0, 32'(tune_active));
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    s_defaults();
    s_ranges();
    s_clamp();
    s_override();
    s_heatcool();
    s_tune();
    final_report();
  end
endmodule
`default_nettype wire
